/* hw/aar_pkg.sv */
package aar_pkg;

    // ---------------------------------------------------------------
    // sizes
    // ---------------------------------------------------------------
    localparam int NUM_CLS = 16;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int DLY_W = 12;
    localparam int CNT_W = 4;
    localparam int TICK_W = 25;
    localparam int DECAY_W = 10;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned SEC_TIME_S = 1;
    localparam int unsigned SEC_CYCLES = SEC_TIME_S * CLK_HZ;
    localparam int unsigned DECAY_TIME_S = 600;
    localparam int unsigned DECAY_TICKS = DECAY_TIME_S / SEC_TIME_S;

    // ---------------------------------------------------------------
    // alarm classes
    // ---------------------------------------------------------------
    localparam int CL_MOTOR_THERMAL = 0;
    localparam int CL_TEMP_SENSOR = 1;
    localparam int CL_THERMISTOR = 2;
    localparam int CL_STALLED_ROTOR = 3;
    localparam int CL_CURRENT_LIMIT = 4;
    localparam int CL_COMM_ERROR = 5;
    localparam int CL_LOAD_HIGH_ALARM = 6;
    localparam int CL_LOAD_HIGH_PREWARN = 7;
    localparam int CL_LOAD_LOW_PREWARN = 8;
    localparam int CL_LOAD_LOW_ALARM = 9;
    localparam int CL_EXT_ALARM1 = 10;
    localparam int CL_EXT_ALARM2 = 11;
    localparam int CL_OVERTEMP = 12;
    localparam int CL_START_LIMIT = 13;
    localparam int CL_PHASE_LOSS = 14;
    localparam int CL_VOLT_UNBAL = 15;

    // ---------------------------------------------------------------
    // register map (word offsets) and reset values
    // ---------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_DELAY_BASE = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_ALLOWED = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_ACTUAL = 8'h11;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h12;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h13;
    localparam logic [ADDR_W-1:0] OFS_PENDING = 8'h14;
    localparam logic [DATA_W-1:0] DLY_MAX = 16'h0e10;
    localparam logic [DATA_W-1:0] ALLOW_MAX = 16'h000a;
    localparam logic [DLY_W-1:0] DLY_RST = 12'h000;
    localparam logic [CNT_W-1:0] ALLOW_RST = 4'h0;
    localparam int IRQ_RESTART = 0;
    localparam int IRQ_LIMIT = 1;

    typedef struct packed {
        logic [TICK_W-1:0] tick_cnt;
        logic tick;
        logic [NUM_CLS-1:0][DLY_W-1:0] dly;
        logic [NUM_CLS-1:0][DLY_W-1:0] cnt;
        logic [NUM_CLS-1:0] pend;
        logic [NUM_CLS-1:0] expd;
        logic [CNT_W-1:0] count;
        logic [CNT_W-1:0] allowed;
        logic [DECAY_W-1:0] decay_cnt;
        logic limit_hit;
        logic [NUM_CLS-1:0] clr;
        logic restart;
        logic [1:0] irq_st;
        logic [1:0] irq_mask;
        logic [1:0][2:0] ext_sync;
        logic [1:0] ext_lvl;
        logic [DATA_W-1:0] rdata;
    } aar_state_t;

endpackage : aar_pkg

/* hw/aar_timers.sv */
`timescale 1ns/1ps

module aar_timers #(
    parameter int unsigned TICK_CYCLES = aar_pkg::SEC_CYCLES
) (
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic [aar_pkg::ADDR_W-1:0] ADDR_I,
    input wire logic [aar_pkg::DATA_W-1:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [aar_pkg::DATA_W-1:0] RDATA_O,
    input wire logic [aar_pkg::NUM_CLS-1:0] ALARM_TRIP_I,
    input wire logic THERM_PROT_EN_I,
    input wire logic THERM_COOLED_I,
    input wire logic SENSOR_BELOW_I,
    input wire logic THERMISTOR_OK_I,
    input wire logic COMM_OK_I,
    input wire logic [1:0] EXT_ALARM_I,
    input wire logic OVERTEMP_I,
    input wire logic START_WAIT_ZERO_I,
    input wire logic UNBAL_FAULT_I,
    input wire logic MAINS_PRESENT_I,
    input wire logic RAMP_ACTIVE_I,
    input wire logic NORMAL_RESET_I,
    output logic [aar_pkg::NUM_CLS-1:0] ALARM_CLEAR_O,
    output logic RESTART_O,
    output logic [aar_pkg::CNT_W-1:0] RETRY_COUNT_O,
    output logic LIMIT_HIT_O,
    output logic IRQ_O
);
    import aar_pkg::*;

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    aar_state_t st_r;
    aar_state_t st_nxt;
    logic [NUM_CLS-1:0] start_ok;
    logic trip_any;
    logic [CNT_W-1:0] inc;
    logic armable;
    logic [TICK_W-1:0] tick_last;

    assign tick_last = TICK_W'(TICK_CYCLES - 1);
    assign trip_any = |ALARM_TRIP_I;
    assign inc = (st_r.count == 4'hf) ? st_r.count : st_r.count + 4'h1;
    assign armable = (st_r.allowed != 4'h0) && (inc <= st_r.allowed);

    // ---------------------------------------------------------------
    // per-class start conditions
    // ---------------------------------------------------------------
    // without thermal protection the model never blocks, so start at once
    assign start_ok[CL_MOTOR_THERMAL] = !THERM_PROT_EN_I || THERM_COOLED_I;
    assign start_ok[CL_TEMP_SENSOR] = SENSOR_BELOW_I;
    // the source folds the power board thermistor limit into this flag
    assign start_ok[CL_THERMISTOR] = THERMISTOR_OK_I;
    assign start_ok[CL_STALLED_ROTOR] = 1'b1;
    assign start_ok[CL_CURRENT_LIMIT] = 1'b1;
    assign start_ok[CL_COMM_ERROR] = COMM_OK_I;
    assign start_ok[CL_LOAD_HIGH_ALARM] = 1'b1;
    assign start_ok[CL_LOAD_HIGH_PREWARN] = 1'b1;
    assign start_ok[CL_LOAD_LOW_PREWARN] = 1'b1;
    assign start_ok[CL_LOAD_LOW_ALARM] = 1'b1;
    assign start_ok[CL_EXT_ALARM1] = !st_r.ext_lvl[0];
    assign start_ok[CL_EXT_ALARM2] = !st_r.ext_lvl[1];
    assign start_ok[CL_OVERTEMP] = !OVERTEMP_I;
    assign start_ok[CL_START_LIMIT] = START_WAIT_ZERO_I;
    assign start_ok[CL_PHASE_LOSS] = 1'b1;
    // with mains gone the fault cannot be seen, so do not wait on it
    assign start_ok[CL_VOLT_UNBAL] = !UNBAL_FAULT_I || !MAINS_PRESENT_I;

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        int sel;
        logic [DLY_W-1:0] cnt_inc;
        sel = 0;
        cnt_inc = '0;
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        st_nxt.clr = '0;
        st_nxt.restart = 1'b0;
        st_nxt.rdata = '0;

        if (st_r.tick_cnt == tick_last) begin
            st_nxt.tick_cnt = '0;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.tick_cnt = st_r.tick_cnt + 25'h0000001;
        end

        // pin synchronisers: first stage only feeds the second
        for (int k = 0; k < 2; k++) begin
            st_nxt.ext_sync[k] = {st_r.ext_sync[k][1:0], EXT_ALARM_I[k]};
            if (st_r.ext_sync[k][1] == st_r.ext_sync[k][2]) begin
                st_nxt.ext_lvl[k] = st_r.ext_sync[k][2];
            end
        end

        // register writes
        if (WR_I) begin
            if (ADDR_I[7:4] == OFS_DELAY_BASE[7:4]) begin
                // out-of-range delays are dropped so a class never runs wild
                if (WDATA_I <= DLY_MAX) begin
                    st_nxt.dly[ADDR_I[3:0]] = WDATA_I[DLY_W-1:0];
                end
            end else if (ADDR_I == OFS_ALLOWED) begin
                if (WDATA_I <= ALLOW_MAX) begin
                    st_nxt.allowed = WDATA_I[CNT_W-1:0];
                end
            end else if (ADDR_I == OFS_IRQ_STATUS) begin
                st_nxt.irq_st = st_r.irq_st & ~WDATA_I[1:0];
            end else if (ADDR_I == OFS_IRQ_MASK) begin
                st_nxt.irq_mask = WDATA_I[1:0];
            end
        end

        // register reads, data valid in the next cycle only
        if (RD_I) begin
            if (ADDR_I[7:4] == OFS_DELAY_BASE[7:4]) begin
                st_nxt.rdata = {4'h0, st_r.dly[ADDR_I[3:0]]};
            end else if (ADDR_I == OFS_ALLOWED) begin
                st_nxt.rdata = {12'h000, st_r.allowed};
            end else if (ADDR_I == OFS_ACTUAL) begin
                st_nxt.rdata = {12'h000, st_r.count};
            end else if (ADDR_I == OFS_IRQ_STATUS) begin
                st_nxt.rdata = {14'h0000, st_r.irq_st};
            end else if (ADDR_I == OFS_IRQ_MASK) begin
                st_nxt.rdata = {14'h0000, st_r.irq_mask};
            end else if (ADDR_I == OFS_PENDING) begin
                st_nxt.rdata = st_r.pend;
            end
        end

        // delay counters, held at zero until the class may start
        for (int i = 0; i < NUM_CLS; i++) begin
            cnt_inc = st_r.cnt[i] + 12'h001;
            if (st_r.pend[i] && !st_r.expd[i]) begin
                if (!start_ok[i]) begin
                    st_nxt.cnt[i] = '0;
                end else if (st_r.tick) begin
                    st_nxt.cnt[i] = cnt_inc;
                    if (cnt_inc >= st_r.dly[i]) begin
                        st_nxt.expd[i] = 1'b1;
                    end
                end
            end
        end

        // fire the lowest expired class once the ramp is over
        for (int i = NUM_CLS - 1; i >= 0; i--) begin
            if (st_r.expd[i]) begin
                sel = i;
            end
        end
        if ((|st_r.expd) && !RAMP_ACTIVE_I) begin
            st_nxt.clr[sel] = 1'b1;
            st_nxt.restart = 1'b1;
            st_nxt.pend[sel] = 1'b0;
            st_nxt.expd[sel] = 1'b0;
            st_nxt.irq_st[IRQ_RESTART] = 1'b1;
        end

        // a new trip re-arms its class from zero if its delay is nonzero and the retry limit allows it
        for (int i = 0; i < NUM_CLS; i++) begin
            if (ALARM_TRIP_I[i] && armable && (st_r.dly[i] != DLY_RST)) begin
                st_nxt.pend[i] = 1'b1;
                st_nxt.expd[i] = 1'b0;
                st_nxt.cnt[i] = '0;
            end
        end

        // retry count and its decay
        if (trip_any) begin
            st_nxt.count = inc;
            st_nxt.decay_cnt = '0;
            st_nxt.limit_hit = 1'b0;
            if ((st_r.allowed != 4'h0) && (inc > st_r.allowed)) begin
                st_nxt.limit_hit = 1'b1;
                st_nxt.irq_st[IRQ_LIMIT] = 1'b1;
            end
        end else if (st_r.tick) begin
            if (st_r.decay_cnt == DECAY_W'(DECAY_TICKS - 1)) begin
                st_nxt.decay_cnt = '0;
                if (st_r.count != 4'h0) begin
                    st_nxt.count = st_r.count - 4'h1;
                end
            end else begin
                st_nxt.decay_cnt = st_r.decay_cnt + 10'h001;
            end
        end

        // a normal reset outranks a trip in the same cycle
        if (NORMAL_RESET_I) begin
            st_nxt.count = '0;
            st_nxt.decay_cnt = '0;
            st_nxt.limit_hit = 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            st_r <= '0;
            for (int i = 0; i < NUM_CLS; i++) begin
                st_r.dly[i] <= DLY_RST;
            end
            st_r.allowed <= ALLOW_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign RDATA_O = st_r.rdata;
    assign ALARM_CLEAR_O = st_r.clr;
    assign RESTART_O = st_r.restart;
    assign RETRY_COUNT_O = st_r.count;
    assign LIMIT_HIT_O = st_r.limit_hit;
    assign IRQ_O = |(st_r.irq_st & st_r.irq_mask);

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    count_zero_a: assert property (
        @(posedge CLK_I) disable iff (SYS_RST_I)
        NORMAL_RESET_I |=> (RETRY_COUNT_O == 4'h0) && !LIMIT_HIT_O)
        else $error("normal reset did not zero retry count");

    ramp_hold_a: assert property (
        @(posedge CLK_I) disable iff (SYS_RST_I)
        $rose(RESTART_O) |-> !$past(RAMP_ACTIVE_I))
        else $error("restart issued during ramp");

    restart_clear_a: assert property (
        @(posedge CLK_I) disable iff (SYS_RST_I)
        RESTART_O |-> $onehot(ALARM_CLEAR_O) ##1 !RESTART_O)
        else $error("restart without single alarm clear");

    off_class_a: assert property (
        @(posedge CLK_I) disable iff (SYS_RST_I)
        (st_r.dly[CL_STALLED_ROTOR] == DLY_RST) && !st_r.pend[CL_STALLED_ROTOR]
        |=> !st_r.pend[CL_STALLED_ROTOR])
        else $error("disabled class was armed");

    tick_period_a: assert property (
        @(posedge CLK_I) disable iff (SYS_RST_I)
        st_r.tick |-> $past(st_r.tick_cnt) == tick_last)
        else $error("tick not at end of second");

    decay_step_a: assert property (
        @(posedge CLK_I) disable iff (SYS_RST_I)
        (RETRY_COUNT_O < $past(RETRY_COUNT_O)) && !$past(NORMAL_RESET_I)
        |-> $past(st_r.decay_cnt) == DECAY_W'(DECAY_TICKS - 1))
        else $error("retry count decayed early");

    limit_mark_a: assert property (
        @(posedge CLK_I) disable iff (SYS_RST_I)
        $rose(LIMIT_HIT_O) |-> (RETRY_COUNT_O > st_r.allowed) && (st_r.allowed != 4'h0))
        else $error("limit marked below allowed count");

    stall_count_a: assert property (
        @(posedge CLK_I) disable iff (SYS_RST_I)
        st_r.pend[CL_STALLED_ROTOR] && !st_r.expd[CL_STALLED_ROTOR] && st_r.tick
        && !ALARM_TRIP_I[CL_STALLED_ROTOR]
        |=> st_r.cnt[CL_STALLED_ROTOR] == $past(st_r.cnt[CL_STALLED_ROTOR]) + 12'h001)
        else $error("stalled rotor delay not counting");

    ext_wait_a: assert property (
        @(posedge CLK_I) disable iff (SYS_RST_I)
        st_r.pend[CL_EXT_ALARM1] && st_r.ext_lvl[0] |=> st_r.cnt[CL_EXT_ALARM1] == '0)
        else $error("external delay ran while input active");

    comm_wait_a: assert property (
        @(posedge CLK_I) disable iff (SYS_RST_I)
        st_r.pend[CL_COMM_ERROR] && !COMM_OK_I |=> st_r.cnt[CL_COMM_ERROR] == '0)
        else $error("comm delay ran without link");

    clear_with_restart_a: assert property (
        @(posedge CLK_I) disable iff (SYS_RST_I)
        (ALARM_CLEAR_O != '0) |-> RESTART_O)
        else $error("alarm cleared without restart");

    allowed_range_a: assert property (
        @(posedge CLK_I) disable iff (SYS_RST_I)
        st_r.allowed <= ALLOW_MAX[CNT_W-1:0])
        else $error("allowed retry limit out of range");

    delay_range_a: assert property (
        @(posedge CLK_I) disable iff (SYS_RST_I)
        st_r.dly[CL_OVERTEMP] <= DLY_MAX[DLY_W-1:0])
        else $error("delay setting out of range");

    trip_counts_a: assert property (
        @(posedge CLK_I) disable iff (SYS_RST_I)
        trip_any && !NORMAL_RESET_I |=> RETRY_COUNT_O != 4'h0)
        else $error("trip not counted");

    tick_single_a: assert property (
        @(posedge CLK_I) disable iff (SYS_RST_I)
        st_r.tick |=> !st_r.tick)
        else $error("tick longer than one cycle");

    therm_wait_a: assert property (
        @(posedge CLK_I) disable iff (SYS_RST_I)
        st_r.pend[CL_MOTOR_THERMAL] && THERM_PROT_EN_I && !THERM_COOLED_I
        |=> st_r.cnt[CL_MOTOR_THERMAL] == '0)
        else $error("thermal delay ran before model cooled");

    sensor_wait_a: assert property (
        @(posedge CLK_I) disable iff (SYS_RST_I)
        st_r.pend[CL_TEMP_SENSOR] && !SENSOR_BELOW_I |=> st_r.cnt[CL_TEMP_SENSOR] == '0)
        else $error("sensor delay ran while hot");

    thermistor_wait_a: assert property (
        @(posedge CLK_I) disable iff (SYS_RST_I)
        st_r.pend[CL_THERMISTOR] && !THERMISTOR_OK_I |=> st_r.cnt[CL_THERMISTOR] == '0)
        else $error("thermistor delay ran above limit");

    overtemp_wait_a: assert property (
        @(posedge CLK_I) disable iff (SYS_RST_I)
        st_r.pend[CL_OVERTEMP] && OVERTEMP_I |=> st_r.cnt[CL_OVERTEMP] == '0)
        else $error("overtemperature delay ran while hot");

    unbal_wait_a: assert property (
        @(posedge CLK_I) disable iff (SYS_RST_I)
        st_r.pend[CL_VOLT_UNBAL] && UNBAL_FAULT_I && MAINS_PRESENT_I
        |=> st_r.cnt[CL_VOLT_UNBAL] == '0)
        else $error("unbalance delay ran with fault seen");

endmodule : aar_timers

/* sim/aar_plant.sv */
`timescale 1ns/1ps

module aar_plant (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [15:0] hold_i,
    input wire logic prot_off_i,
    input wire logic mains_off_i,
    input wire logic ramp_force_i,
    input wire logic restart_i,
    output logic therm_en_o,
    output logic cooled_o,
    output logic sensor_ok_o,
    output logic ptc_ok_o,
    output logic comm_ok_o,
    output logic [1:0] ext_o,
    output logic overtemp_o,
    output logic wait_zero_o,
    output logic unbal_o,
    output logic mains_o,
    output logic ramp_o
);
    logic [1:0] ramp_left_r;

    // a restart launches a short start ramp, so back-to-back restarts get spaced out
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ramp_left_r <= 2'h0;
        end else if (restart_i) begin
            ramp_left_r <= 2'h3;
        end else if (ramp_left_r != 2'h0) begin
            ramp_left_r <= ramp_left_r - 2'h1;
        end
    end

    // the restart cycle itself already counts as ramp, so no second restart slips in behind it
    assign ramp_o = ramp_force_i || restart_i || (ramp_left_r != 2'h0);
    // a held class with a start condition keeps its fault present, so that condition stays false; classes 3, 4, 6-9 and 14 have none
    assign therm_en_o = ~prot_off_i;
    assign cooled_o = ~hold_i[0];
    assign sensor_ok_o = ~hold_i[1];
    assign ptc_ok_o = ~hold_i[2];
    assign comm_ok_o = ~hold_i[5];
    assign ext_o = hold_i[11:10];
    assign overtemp_o = hold_i[12];
    assign wait_zero_o = ~hold_i[13];
    assign unbal_o = hold_i[15];
    assign mains_o = ~mains_off_i;
endmodule : aar_plant

/* sim/tb_top.sv */
`timescale 1ns/1ps

module tb_top;
    import aar_pkg::*;
    localparam int TK = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [NUM_CLS-1:0] trip = '0;
    logic [NUM_CLS-1:0] hold = '0;
    logic prot_off = 1'b0;
    logic mains_off = 1'b0;
    logic ramp_force = 1'b0;
    logic nreset = 1'b0;
    logic th_en, cooled, sens_ok, ptc_ok, comm_ok, otemp, swz, unbal, mains, ramp;
    logic restart, limit, irq, imm;
    logic [1:0] ext;
    logic [NUM_CLS-1:0] clr;
    logic [DATA_W-1:0] rdata;
    logic [CNT_W-1:0] cnt;
    int miscompares = 0;
    int n_tests = 0;
    int seed = 32'hb9a2e757;
    int exp_cnt = 0;
    int shadow [0:16] = '{default: 0};
    int n, d;

    always #25 clk = ~clk;

    aar_timers #(.TICK_CYCLES(TK)) dut_u (.CLK_I(clk), .SYS_RST_I(rst), .ADDR_I(addr),
        .WDATA_I(wdata), .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata), .ALARM_TRIP_I(trip),
        .THERM_PROT_EN_I(th_en), .THERM_COOLED_I(cooled), .SENSOR_BELOW_I(sens_ok),
        .THERMISTOR_OK_I(ptc_ok), .COMM_OK_I(comm_ok), .EXT_ALARM_I(ext), .OVERTEMP_I(otemp),
        .START_WAIT_ZERO_I(swz), .UNBAL_FAULT_I(unbal), .MAINS_PRESENT_I(mains),
        .RAMP_ACTIVE_I(ramp), .NORMAL_RESET_I(nreset), .ALARM_CLEAR_O(clr),
        .RESTART_O(restart), .RETRY_COUNT_O(cnt), .LIMIT_HIT_O(limit), .IRQ_O(irq));

    aar_plant plant_u (.clk_i(clk), .rst_i(rst), .hold_i(hold), .prot_off_i(prot_off),
        .mains_off_i(mains_off), .ramp_force_i(ramp_force), .restart_i(restart),
        .therm_en_o(th_en), .cooled_o(cooled), .sensor_ok_o(sens_ok), .ptc_ok_o(ptc_ok),
        .comm_ok_o(comm_ok), .ext_o(ext), .overtemp_o(otemp), .wait_zero_o(swz),
        .unbal_o(unbal), .mains_o(mains), .ramp_o(ramp));

    // ---------------------------------------------------------------
    // bus and stimulus tasks
    // ---------------------------------------------------------------
    task automatic chk(input string what, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask : chk

    // the model keeps the settings, refusing out-of-range values
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
        if (a < 8'h10 && v <= 16'd3600) shadow[a] = v;
        if (a == OFS_ALLOWED && v <= 16'd10) shadow[16] = v;
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        chk("rdata", e, rdata);
    endtask : rd

    task automatic fire(input logic [NUM_CLS-1:0] v);
        @(posedge clk);
        trip <= v;
        @(posedge clk);
        trip <= '0;
        exp_cnt = (exp_cnt < 15) ? exp_cnt + 1 : 15;
    endtask : fire

    task automatic pulse_nr();
        @(posedge clk);
        nreset <= 1'b1;
        @(posedge clk);
        nreset <= 1'b0;
        exp_cnt = 0;
    endtask : pulse_nr

    // n reaches max when no clear pulse came
    task automatic wait_clr(input int i, input int max, output int n);
        for (n = 0; n < max; n++) begin
            @(posedge clk);
            #1;
            if (clr[i] === 1'b1) begin
                chk("restart", 16'h1, {15'h0, restart});
                break;
            end
        end
    endtask : wait_clr

    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    initial begin
        #(40000 * 50);
        miscompares++;
        wrap_up();
    end

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 21; a++) rd(a[7:0], 16'h0);
        wr(8'h20, 16'($random(seed)));
        rd(8'h20, 16'h0);
        wr(OFS_ALLOWED, 16'd11);
        wr(8'h00, 16'd3601);
        wr(8'h01, 16'd3600);
        rd(OFS_ALLOWED, 16'(shadow[16]));
        rd(8'h00, 16'(shadow[0]));
        rd(8'h01, 16'(shadow[1]));
        wr(OFS_ALLOWED, 16'd3);
        wr(OFS_IRQ_MASK, 16'h1);
        for (int i = 0; i < NUM_CLS; i++) begin
            d = 1 + ($random(seed) & 1);
            imm = i inside {3, 4, 6, 7, 8, 9, 14};
            wr(i[7:0], 16'(d));
            pulse_nr();
            hold <= NUM_CLS'(1) << i;
            fire(NUM_CLS'(1) << i);
            wait_clr(i, 3 * TK, n);
            chk("early clear", {15'h0, imm}, {15'h0, n < 3 * TK});
            hold <= '0;
            if (!imm) wait_clr(i, d * TK + 8, n);
            chk("delay", 16'h1, {15'h0, n + 2 >= (d - 1) * TK && n < d * TK + 8});
            chk("irq", 16'h1, {15'h0, irq});
            wr(OFS_IRQ_STATUS, 16'h1);
            @(posedge clk);
            #1;
            chk("irq", 16'h0, {15'h0, irq});
        end
        // protection off and mains absent let held classes 0 and 15 start; lowest goes first
        wr(8'h00, 16'd1);
        wr(8'h0f, 16'd1);
        pulse_nr();
        prot_off <= 1'b1;
        mains_off <= 1'b1;
        hold <= '1;
        fire(16'h8001);
        wait_clr(0, 2 * TK + 4, n);
        chk("clear", 16'h1, {15'h0, n < 2 * TK + 4});
        wait_clr(15, 8, n);
        chk("clear", 16'h1, {15'h0, n < 8});
        hold <= '0;
        ramp_force <= 1'b1;
        pulse_nr();
        fire(16'h0008);
        wait_clr(3, 3 * TK, n);
        chk("held by ramp", 16'h1, {15'h0, n == 3 * TK});
        ramp_force <= 1'b0;
        wait_clr(3, 6, n);
        chk("clear", 16'h1, {15'h0, n < 6});
        pulse_nr();
        wr(OFS_ALLOWED, 16'd1);
        wr(OFS_IRQ_MASK, 16'h3);
        fire(16'h0008);
        wait_clr(3, 3 * TK, n);
        fire(16'h0008);
        repeat (2) @(posedge clk);
        #1;
        chk("limit", 16'h1, {15'h0, limit});
        wait_clr(3, 3 * TK, n);
        chk("no retry", 16'h1, {15'h0, n == 3 * TK});
        rd(OFS_IRQ_STATUS, 16'h3);
        wr(OFS_ACTUAL, 16'h5);
        rd(OFS_ACTUAL, 16'(exp_cnt));
        wr(OFS_IRQ_STATUS, 16'h3);
        repeat (600 * TK - 120) @(posedge clk);
        rd(OFS_ACTUAL, 16'(exp_cnt));
        repeat (100) @(posedge clk);
        exp_cnt = exp_cnt - 1;
        rd(OFS_ACTUAL, 16'(exp_cnt));
        chk("irq", 16'h0, {15'h0, irq});
        pulse_nr();
        rd(OFS_ACTUAL, 16'(exp_cnt));
        chk("limit", 16'h0, {15'h0, limit});
        chk("count", 16'(exp_cnt), {12'h000, cnt});
        wrap_up();
    end
endmodule : tb_top
